/* File: include/ccs_defines.vh */
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
// Register offsets on the host serial port address space (17-bit byte addresses).
`define CCS_ADDR_SOFT_RESET   17'h10600
`define CCS_ADDR_PRI_TRIGGER  17'h10601
`define CCS_ADDR_SEC_TRIGGER  17'h10602
`define CCS_ADDR_MAIN_STATE   17'h10604
`define CCS_ADDR_STD_SERIAL   17'h10606
`define CCS_ADDR_RANDOM       17'h10608
`define CCS_ADDR_CIPHER       17'h10609
`define CCS_ADDR_KEY_AGREE    17'h1060a
`define CCS_ADDR_CNT_BACKUP   17'h1060b
`define CCS_ADDR_OVERWRITE    17'h1060f
`define CCS_ADDR_ENGINE       17'h10619
`define CCS_ADDR_ZONE_SEL     17'h1061a
`define CCS_ADDR_PAGE_READ    17'h1061c
`define CCS_ADDR_ROOT_SERIAL  17'h1061d
// Write buffer window, 64 bytes.
`define CCS_ADDR_BUF_BASE     17'h10100
`define CCS_BUF_DEPTH         64
// Field positions.
`define CCS_BIT_CIPHER_RST    0
`define CCS_BIT_NVM_RST       1
`define CCS_ZONE_PAGE_HI      3
`define CCS_ZONE_SUB_LO       4
`define CCS_ZONE_SLICE_LO     6
// Reset values.
`define CCS_RESET_VALUE       8'h00
// Main state encodings.
`define CCS_MAIN_IDLE         4'h1
`define CCS_MAIN_CM_ZONE      4'h5
`define CCS_MAIN_STD_SERIAL   4'h6
`define CCS_MAIN_NVM_CONFIG   4'h7
`define CCS_MAIN_RANDOM       4'h8
`define CCS_MAIN_CIPHER       4'h9
`define CCS_MAIN_KEY_AGREE    4'ha
`define CCS_MAIN_CNT_BACKUP   4'hb
`define CCS_MAIN_PERMISSION   4'hc
`define CCS_MAIN_OVERWRITE    4'hf
// Sub-state encodings.
`define CCS_SUB_IDLE3         3'h1
`define CCS_SUB_HASH          3'h4
`define CCS_SUB_HOST_RND      3'h2
`define CCS_SUB_HW_RND        3'h4
`define CCS_ENG_DEC_WR        4'he
// User zone layout.
`define CCS_ZONE_BASE         16'hf000
`define CCS_SUBPAGE_BYTES     8'h40
`endif

/* File: verilog/ccs_write_buffer.v */
`timescale 1ns/1ps
// Byte-wide 64-entry write buffer with a registered read port.
module ccs_write_buffer (
  // Clock.
  input  wire       clk_sys,
  // Write port.
  input  wire       wrEn,
  input  wire [5:0] wrAddr,
  input  wire [7:0] wrData,
  // Read port.
  input  wire [5:0] rdAddr,
  output reg  [7:0] rdData
);
  // Storage array; contents are undefined until written or loaded.
  reg [7:0] mem [0:63];

  // One write and one registered read per cycle.
  always @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // ccs_write_buffer

/* File: verilog/ccs_state_decode.v */
`timescale 1ns/1ps
// Validates every state-selection field so that reserved codes never launch work.
module ccs_state_decode (
  // Field values.
  input  wire [3:0] mainSel,
  input  wire [2:0] stdSel,
  input  wire [2:0] rndSel,
  input  wire [3:0] cipherSel,
  input  wire [2:0] agreeSel,
  input  wire [2:0] owSel,
  input  wire [3:0] engineSel,
  input  wire [2:0] rootSel,
  // Results.
  output wire       mainOk,
  output wire       subOk
);
`include "ccs_defines.vh"

  // Main state codes that name a function.
  function mainValid;
    input [3:0] v;
    begin
      mainValid = (v == `CCS_MAIN_IDLE) || (v >= `CCS_MAIN_CM_ZONE && v <= `CCS_MAIN_PERMISSION) ||
                  (v == `CCS_MAIN_OVERWRITE); // [RL5]
    end
  endfunction

  // Sub-state check for the function that the main field selects.
  reg okSub;
  always @* begin
    okSub = 1'b1;
    case (mainSel)
      `CCS_MAIN_STD_SERIAL: okSub = (stdSel == `CCS_SUB_HASH) || (stdSel == `CCS_SUB_IDLE3); // [RL8]
      `CCS_MAIN_RANDOM:     okSub = (rndSel == `CCS_SUB_HOST_RND) || (rndSel == `CCS_SUB_HW_RND); // [RL9]
      `CCS_MAIN_CIPHER: begin
        // Cipher codes C and D are reserved; the engine codes A..D are hardware-only.
        okSub = (cipherSel != 4'h0) && (cipherSel != 4'hc) && (cipherSel != 4'hd) && // [RL10]
                (engineSel != 4'h0) && !(engineSel >= 4'ha && engineSel <= 4'hd) && // [RL15] [RL16]
                (engineSel < 4'h5 || engineSel > 4'h7) &&
                (cipherSel != 4'h7 || rootSel == 3'h1 || rootSel == 3'h2 || rootSel == 3'h3 ||
                 rootSel == 3'h4 || rootSel == 3'h7); // [RL23]
      end
      `CCS_MAIN_KEY_AGREE:  okSub = (agreeSel >= 3'h1) && (agreeSel <= 3'h3); // [RL11]
      `CCS_MAIN_OVERWRITE:  okSub = (owSel >= 3'h1) && (owSel <= 3'h4); // [RL13]
      default:              okSub = 1'b1;
    endcase
  end

  assign mainOk = mainValid(mainSel);
  assign subOk  = okSub;
endmodule // ccs_state_decode

/* File: verilog/ccs_ctrl_regs.v */
`timescale 1ns/1ps
// Summary of operation
// RL1: Bit 0 pulse one-then-zero resets cipher.
// RL2: Bit 1 one-then-zero resets the EEPROM.
// RL3: Primary trigger stores nothing, launches programmed state.
// RL4: Secondary trigger launches overwrite-control action.
// RL5: Main field decodes ten function codes, reset zero.
// RL6: Host ends operations with idle plus trigger.
// RL7: Host sequences main states through idle.
// RL8: Standard serial sub-state 4 selects hashing.
// RL9: Random sub-state 2 host, 4 hardware.
// RL10: Cipher sub-state field decodes fifteen codes; the trigger accepts only thirteen, refusing 0, C and D.
// RL11: Key-agreement sub-state decodes idle, generate, crypt.
// RL12: Counter backup bit starts backup procedure.
// RL13: Overwrite sub-state decodes idle, detour, destroys.
// RL14: Host restores standby before next operation.
// RL15: Engine sub-state decodes, A through D reserved.
// RL16: Engine code E decrypts and stores plaintext.
// RL17: Zone page selects fifteen 256-byte zones.
// RL18: Subpage field selects 64-byte subpage offset.
// RL19: Slice field selects 128-bit page slice.
// RL20: Zone access by page or sub-page.
// RL21: Page-read trigger copies page into buffer.
// RL22: Root serial runs via trigger, ends idle.
// RL23: Root serial sub-state decodes five codes.
// RL24: Write buffer serves cipher and EEPROM writes.
// RL25: Reserved codes plus trigger start nothing.
module ccs_ctrl_regs (
  // Clock and reset.
  input  wire        clk_sys,
  input  wire        rst,
  // Register access from the host serial port.
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [16:0] regAddr,
  input  wire [7:0]  regWdata,
  output reg  [7:0]  regRdata,
  output reg         regRvalid,
  // Soft resets towards the cipher and EEPROM.
  output reg         cipherSoftReset,
  output reg         eepromSoftReset,
  // Active state towards the cipher hardware.
  output reg  [3:0]  activeMain,
  output reg  [3:0]  activeSub,
  output reg  [3:0]  activeEngine,
  output reg  [2:0]  activeRoot,
  output reg         launch,
  output reg         overwriteLaunch,
  output reg         counterBackupStart,
  output reg         decryptToNvm,
  // EEPROM addressing and page load.
  output reg  [15:0] nvmPageAddr,
  output reg  [1:0]  zoneSliceNumber,
  output reg         pageLoad,
  input  wire        pageLoadValid,
  input  wire [5:0]  pageLoadIndex,
  input  wire [7:0]  pageLoadData,
  // Cipher result write-back into the write buffer.
  input  wire        cipherBufWrite,
  input  wire [5:0]  cipherBufIndex,
  input  wire [7:0]  cipherBufData
);
`include "ccs_defines.vh"

  // Programmed selection registers.
  reg  [1:0] softReset;        // Soft reset control bits.
  reg  [3:0] mainStateSelect;  // Main state field.
  reg  [2:0] stdSerialSub;     // Standard serial sub-state.
  reg  [2:0] randomSub;        // Random sub-state.
  reg  [3:0] cipherSub;        // Cipher sub-state.
  reg  [2:0] keyAgreeSub;      // Key agreement sub-state.
  reg        counterBackup;    // Counter backup start bit.
  reg  [2:0] overwriteSub;     // Overwrite control sub-state.
  reg  [3:0] engineSub;        // Second level cipher sub-state.
  reg  [7:0] userZoneSelect;   // Zone, subpage and slice selection.
  reg  [2:0] rootSerialSub;    // Root serial creation sub-state.
  reg        bufReadPending;   // A buffer read waits on the memory latency.
  wire       mainOk;           // Programmed main code is a valid function.
  wire       subOk;            // Programmed sub-state code is valid.
  wire       bufHit;           // Access lands in the write buffer window.
  wire       bufWe;            // Write strobe into the buffer memory.
  wire [5:0] bufWaddr;         // Write index into the buffer memory.
  wire [7:0] bufWdata;         // Write data into the buffer memory.
  wire [7:0] bufRdata;         // Registered read data of the buffer.
  reg  [7:0] next_rdata;       // Register read mux.

  // Decode of a buffer window address, used by reads and writes.
  function inBuffer;
    input [16:0] a;
    begin
      inBuffer = (a >= `CCS_ADDR_BUF_BASE) && (a < `CCS_ADDR_BUF_BASE + 17'h00040);
    end
  endfunction

  assign bufHit = inBuffer(regAddr);

  // The buffer is shared: EEPROM page loads win, then cipher results, then the host. [RL24]
  assign bufWe    = pageLoadValid | cipherBufWrite | (regWrite & bufHit);
  assign bufWaddr = pageLoadValid ? pageLoadIndex : (cipherBufWrite ? cipherBufIndex : regAddr[5:0]);
  assign bufWdata = pageLoadValid ? pageLoadData : (cipherBufWrite ? cipherBufData : regWdata);

  ccs_write_buffer u_buf (
    .clk_sys (clk_sys),
    .wrEn    (bufWe),
    .wrAddr  (bufWaddr),
    .wrData  (bufWdata),
    .rdAddr  (regAddr[5:0]),
    .rdData  (bufRdata)
  );

  ccs_state_decode u_dec (
    .mainSel   (mainStateSelect),
    .stdSel    (stdSerialSub),
    .rndSel    (randomSub),
    .cipherSel (cipherSub),
    .agreeSel  (keyAgreeSub),
    .owSel     (overwriteSub),
    .engineSel (engineSub),
    .rootSel   (rootSerialSub),
    .mainOk    (mainOk),
    .subOk     (subOk)
  );

  // Host writes to the stored registers; trigger addresses have no storage.
  always @(posedge clk_sys) begin
    if (rst) begin
      softReset       <= 2'h0;
      mainStateSelect <= 4'h0; // [RL5]
      stdSerialSub    <= 3'h0;
      randomSub       <= 3'h0;
      cipherSub       <= 4'h0;
      keyAgreeSub     <= 3'h0;
      counterBackup   <= 1'b0;
      overwriteSub    <= 3'h0;
      engineSub       <= 4'h0;
      userZoneSelect  <= `CCS_RESET_VALUE;
      rootSerialSub   <= 3'h0; // [RL23]
    end else if (regWrite) begin
      case (regAddr)
        `CCS_ADDR_SOFT_RESET:  softReset       <= regWdata[1:0];
        `CCS_ADDR_MAIN_STATE:  mainStateSelect <= regWdata[3:0];
        `CCS_ADDR_STD_SERIAL:  stdSerialSub    <= regWdata[2:0];
        `CCS_ADDR_RANDOM:      randomSub       <= regWdata[2:0];
        `CCS_ADDR_CIPHER:      cipherSub       <= regWdata[3:0];
        `CCS_ADDR_KEY_AGREE:   keyAgreeSub     <= regWdata[2:0];
        `CCS_ADDR_CNT_BACKUP:  counterBackup   <= regWdata[0]; // [RL12]
        `CCS_ADDR_OVERWRITE:   overwriteSub    <= regWdata[2:0];
        `CCS_ADDR_ENGINE:      engineSub       <= regWdata[3:0];
        `CCS_ADDR_ZONE_SEL:    userZoneSelect  <= regWdata;
        `CCS_ADDR_ROOT_SERIAL: rootSerialSub   <= regWdata[2:0];
        default:               softReset       <= softReset;
      endcase
    end
  end

  // Soft resets follow the stored bits, so a one-then-zero write pulses them.
  always @(posedge clk_sys) begin
    if (rst) begin
      cipherSoftReset <= 1'b0;
      eepromSoftReset <= 1'b0;
    end else begin
      cipherSoftReset <= softReset[`CCS_BIT_CIPHER_RST]; // [RL1]
      eepromSoftReset <= softReset[`CCS_BIT_NVM_RST];    // [RL2]
    end
  end

  // Trigger handling: a write to the primary trigger commits the programmed state.
  // A reserved code is ignored so that the running state stays intact.
  always @(posedge clk_sys) begin
    if (rst) begin
      activeMain      <= 4'h0;
      activeSub       <= 4'h0;
      activeEngine    <= 4'h0;
      activeRoot      <= 3'h0;
      launch          <= 1'b0;
      overwriteLaunch <= 1'b0;
      decryptToNvm    <= 1'b0;
    end else begin
      launch          <= 1'b0;
      overwriteLaunch <= 1'b0;
      if (regWrite && regAddr == `CCS_ADDR_PRI_TRIGGER && mainOk && subOk) begin // [RL3] [RL25]
        // Finishing with the idle code returns the device to standby. [RL6] [RL22]
        activeMain   <= mainStateSelect;
        activeEngine <= engineSub;
        activeRoot   <= rootSerialSub; // [RL22]
        launch       <= 1'b1;
        decryptToNvm <= (mainStateSelect == `CCS_MAIN_CIPHER) && (engineSub == `CCS_ENG_DEC_WR); // [RL16]
        case (mainStateSelect)
          `CCS_MAIN_STD_SERIAL: activeSub <= {1'b0, stdSerialSub};  // [RL8]
          `CCS_MAIN_RANDOM:     activeSub <= {1'b0, randomSub};     // [RL9]
          `CCS_MAIN_CIPHER:     activeSub <= cipherSub;             // [RL10]
          `CCS_MAIN_KEY_AGREE:  activeSub <= {1'b0, keyAgreeSub};   // [RL11]
          `CCS_MAIN_OVERWRITE:  activeSub <= {1'b0, overwriteSub};  // [RL13]
          default:              activeSub <= 4'h0;
        endcase
      end
      if (regWrite && regAddr == `CCS_ADDR_SEC_TRIGGER && activeMain == `CCS_MAIN_OVERWRITE &&
          overwriteSub >= 3'h1 && overwriteSub <= 3'h4) begin // [RL4] [RL13]
        activeSub       <= {1'b0, overwriteSub};
        overwriteLaunch <= 1'b1;
      end
    end
  end

  // Counter backup start is presented while the main state is the backup function.
  always @(posedge clk_sys) begin
    if (rst) begin
      counterBackupStart <= 1'b0;
    end else begin
      counterBackupStart <= counterBackup && (activeMain == `CCS_MAIN_CNT_BACKUP); // [RL12]
    end
  end

  // Zone address: zone n sits at 0xF000 + n*256, subpage adds 64-byte steps.
  // Zone zero is reserved; it maps to no zone and produces no page load.
  always @(posedge clk_sys) begin
    if (rst) begin
      nvmPageAddr     <= 16'h0000;
      zoneSliceNumber <= 2'h0;
      pageLoad        <= 1'b0;
    end else begin
      nvmPageAddr     <= `CCS_ZONE_BASE + {4'h0, userZoneSelect[`CCS_ZONE_PAGE_HI:0], 8'h00} +
                         {8'h00, userZoneSelect[`CCS_ZONE_SUB_LO+1:`CCS_ZONE_SUB_LO], 6'h00}; // [RL17] [RL18] [RL20]
      zoneSliceNumber <= userZoneSelect[`CCS_ZONE_SLICE_LO+1:`CCS_ZONE_SLICE_LO]; // [RL19]
      pageLoad        <= regWrite && (regAddr == `CCS_ADDR_PAGE_READ) &&
                         (userZoneSelect[`CCS_ZONE_PAGE_HI:0] != 4'h0); // [RL21]
    end
  end

  // Read mux for the stored registers; triggers and unmapped addresses read zero.
  always @* begin
    next_rdata = 8'h00;
    case (regAddr)
      `CCS_ADDR_SOFT_RESET:  next_rdata = {6'h00, softReset};
      `CCS_ADDR_MAIN_STATE:  next_rdata = {4'h0, mainStateSelect};
      `CCS_ADDR_STD_SERIAL:  next_rdata = {5'h00, stdSerialSub};
      `CCS_ADDR_RANDOM:      next_rdata = {5'h00, randomSub};
      `CCS_ADDR_CIPHER:      next_rdata = {4'h0, cipherSub};
      `CCS_ADDR_KEY_AGREE:   next_rdata = {5'h00, keyAgreeSub};
      `CCS_ADDR_CNT_BACKUP:  next_rdata = {7'h00, counterBackup};
      `CCS_ADDR_OVERWRITE:   next_rdata = {5'h00, overwriteSub};
      `CCS_ADDR_ENGINE:      next_rdata = {4'h0, engineSub};
      `CCS_ADDR_ZONE_SEL:    next_rdata = userZoneSelect;
      `CCS_ADDR_ROOT_SERIAL: next_rdata = {5'h00, rootSerialSub};
      default:               next_rdata = 8'h00;
    endcase
  end

  // Register reads answer next cycle; buffer reads wait one more for the memory.
  always @(posedge clk_sys) begin
    if (rst) begin
      regRdata       <= 8'h00;
      regRvalid      <= 1'b0;
      bufReadPending <= 1'b0;
    end else begin
      bufReadPending <= regRead & bufHit;
      if (bufReadPending) begin
        regRdata  <= bufRdata;
        regRvalid <= 1'b1;
      end else if (regRead && !bufHit) begin
        regRdata  <= next_rdata;
        regRvalid <= 1'b1;
      end else begin
        regRvalid <= 1'b0;
      end
    end
  end
endmodule // ccs_ctrl_regs

/* File: verification/ccs_ctrl_regs_properties.sv */
`timescale 1ns/1ps
// Port-level checks of the control register block.
module ccs_ctrl_regs_properties (
  // Clock and reset.
  input wire        clk_sys,
  input wire        rst,
  // Host access.
  input wire        regWrite,
  input wire        regRead,
  input wire [16:0] regAddr,
  input wire [7:0]  regWdata,
  input wire [7:0]  regRdata,
  input wire        regRvalid,
  // Results.
  input wire        cipherSoftReset,
  input wire        eepromSoftReset,
  input wire [3:0]  activeMain,
  input wire [3:0]  activeEngine,
  input wire        launch,
  input wire        overwriteLaunch,
  input wire        counterBackupStart,
  input wire        decryptToNvm,
  input wire [15:0] nvmPageAddr,
  input wire        pageLoad
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_launch; launch |-> $past(regWrite) && $past(regAddr) == 17'h10601; endproperty
  a_launch: assert property (p_launch) else $error("launch without trigger");
  // The previous-reset guard keeps the reset drop itself out of the check.
  property p_commit; !$past(rst) && $changed(activeMain) |-> launch; endproperty
  a_commit: assert property (p_commit) else $error("state moved without launch");
  property p_ow;
    overwriteLaunch |-> $past(regWrite) && $past(regAddr) == 17'h10602 && activeMain == 4'hf;
  endproperty
  a_ow: assert property (p_ow) else $error("stray overwrite launch");
  property p_page;
    pageLoad |-> $past(regWrite) && $past(regAddr) == 17'h1061c && nvmPageAddr[11:8] != 4'h0;
  endproperty
  a_page: assert property (p_page) else $error("bad page load");
  property p_rvalid; regRead && regAddr[16:8] == 9'h106 |=> regRvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("register read not answered");
  property p_trig_rd; regRead && (regAddr == 17'h10601 || regAddr == 17'h10602) |=> regRdata == 8'h00; endproperty
  a_trig_rd: assert property (p_trig_rd) else $error("trigger read not zero");
  property p_sr;
    regWrite && regAddr == 17'h10600 |-> ##2
      cipherSoftReset == $past(regWdata[0], 2) && eepromSoftReset == $past(regWdata[1], 2);
  endproperty
  a_sr: assert property (p_sr) else $error("soft reset level wrong");
  property p_cbs; counterBackupStart |-> activeMain == 4'hb; endproperty
  a_cbs: assert property (p_cbs) else $error("backup start outside its state");
  property p_dec; decryptToNvm |-> activeMain == 4'h9 && activeEngine == 4'he; endproperty
  a_dec: assert property (p_dec) else $error("decrypt store outside its state");
  property p_addr; nvmPageAddr != 16'h0000 |-> nvmPageAddr[15:12] == 4'hf && nvmPageAddr[5:0] == 6'h00; endproperty
  a_addr: assert property (p_addr) else $error("page address misaligned");
endmodule // ccs_ctrl_regs_properties

bind ccs_ctrl_regs ccs_ctrl_regs_properties u_props (.clk_sys(clk_sys), .rst(rst), .regWrite(regWrite),
  .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
  .cipherSoftReset(cipherSoftReset), .eepromSoftReset(eepromSoftReset), .activeMain(activeMain),
  .activeEngine(activeEngine), .launch(launch), .overwriteLaunch(overwriteLaunch),
  .counterBackupStart(counterBackupStart), .decryptToNvm(decryptToNvm), .nvmPageAddr(nvmPageAddr),
  .pageLoad(pageLoad));

/* File: verification/ccs_host_model.sv */
`timescale 1ns/1ps
// Host side of the register port; every access is one strobe cycle.
module ccs_host_model (
  // Clock.
  input wire        clk_sys,
  // Register port.
  output reg        regWrite,
  output reg        regRead,
  output reg [16:0] regAddr,
  output reg [7:0]  regWdata,
  input wire [7:0]  regRdata,
  input wire        regRvalid
);
  // Idle values at time zero.
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 17'h00000;
    regWdata = 8'h00;
  end

  // One write, launched and released on rising edges.
  task wr(input [16:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      regWdata <= ~d;
    end
  endtask

  // One read; the answer is awaited for a few cycles only, so a lost answer cannot hang.
  task rd(input [16:0] a, output [7:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRead <= 1'b0;
      n = 0;
      @(posedge clk_sys);
      while (regRvalid !== 1'b1 && n < 4) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      d = regRdata;
    end
  endtask
endmodule // ccs_host_model

/* File: verification/cipher_ctrl_state_registers_tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench of the control register block.
module cipher_ctrl_state_registers_tb_top;
  reg         clk_sys;
  reg         rst;
  wire        regWrite, regRead, regRvalid, cipherSoftReset, eepromSoftReset;
  wire        launch, overwriteLaunch, counterBackupStart, decryptToNvm, pageLoad;
  wire [16:0] regAddr;
  wire [7:0]  regWdata, regRdata;
  wire [3:0]  activeMain, activeEngine, activeSub;
  wire [2:0]  activeRoot;
  wire [15:0] nvmPageAddr;
  wire [1:0]  zoneSliceNumber;
  reg         cipherBufWrite;
  reg         pageLoadValid = 1'b0;
  reg  [5:0]  cipherBufIndex;
  reg  [5:0]  pageLoadIndex = 6'h00;
  reg  [7:0]  cipherBufData, d, v;
  reg  [7:0]  pageLoadData = 8'h00;
  reg  [6:0]  ldCnt = 7'h40;
  reg  [31:0] seed;
  reg  [3:0]  expMain;
  integer     nMismatch, samplesChecked, i;
  integer     cyc = 0;

  ccs_host_model host (.clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
  ccs_ctrl_regs DUT (.clk_sys(clk_sys), .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid), .cipherSoftReset(cipherSoftReset),
    .eepromSoftReset(eepromSoftReset), .activeMain(activeMain), .activeSub(activeSub), .activeEngine(activeEngine),
    .activeRoot(activeRoot), .launch(launch), .overwriteLaunch(overwriteLaunch),
    .counterBackupStart(counterBackupStart),
    .decryptToNvm(decryptToNvm), .nvmPageAddr(nvmPageAddr), .zoneSliceNumber(zoneSliceNumber),
    .pageLoad(pageLoad), .pageLoadValid(pageLoadValid), .pageLoadIndex(pageLoadIndex),
    .pageLoadData(pageLoadData), .cipherBufWrite(cipherBufWrite), .cipherBufIndex(cipherBufIndex),
    .cipherBufData(cipherBufData));

  // Free-running 25 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Next value of the pseudo-random sequence.
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Main codes that a trigger accepts.
  function validMain(input [3:0] c);
    validMain = (c == 4'h1) || (c >= 4'h5 && c <= 4'hc) || (c == 4'hf);
  endfunction

  // Compares and counts; a mismatch is reported at once.
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      samplesChecked = samplesChecked + 1;
      if (seen !== exp) begin
        nMismatch = nMismatch + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Final verdict.
  task results;
    begin
      if (nMismatch == 0 && samplesChecked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // EEPROM stand-in: a page request streams 64 bytes, one per cycle.
  always @(posedge clk_sys) begin
    if (pageLoad === 1'b1)
      ldCnt <= 7'h00;
    else if (!ldCnt[6])
      ldCnt <= ldCnt + 7'h01;
    pageLoadValid <= !ldCnt[6] && pageLoad !== 1'b1;
    pageLoadIndex <= ldCnt[5:0];
    pageLoadData <= {2'b00, ldCnt[5:0]} ^ 8'h5a;
  end

  // Hang guard, far above the length of the sequence.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nMismatch = nMismatch + 1;
      results;
    end
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    {cipherBufWrite, cipherBufIndex, cipherBufData} = 15'h0000;
    seed = 32'h0001149f;
    nMismatch = 0;
    samplesChecked = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      host.rd(17'h10600 + i[16:0], d);
      chk({8'h00, d}, 16'h0000);
    end
    host.wr(17'h10600, 8'h03);
    @(posedge clk_sys);
    #1 chk({14'h0000, cipherSoftReset, eepromSoftReset}, 16'h0003);
    host.wr(17'h10600, 8'h00);
    @(posedge clk_sys);
    #1 chk({14'h0000, cipherSoftReset, eepromSoftReset}, 16'h0000);
    // Valid sub-states first, so only the main code decides.
    host.wr(17'h10606, 8'h04);
    host.wr(17'h10608, 8'h02);
    host.wr(17'h10609, 8'h01);
    host.wr(17'h1060a, 8'h01);
    host.wr(17'h1060f, 8'h01);
    host.wr(17'h10619, 8'h01);
    expMain = 4'h0;
    for (i = 0; i < 16; i = i + 1) begin
      host.wr(17'h10604, i[7:0]);
      host.wr(17'h10601, 8'h00);
      if (validMain(i[3:0]))
        expMain = i[3:0];
      #1 chk({15'h0000, launch}, {15'h0000, validMain(i[3:0])});
      chk({12'h000, activeMain}, {12'h000, expMain});
    end
    host.wr(17'h10604, 8'h01);
    host.wr(17'h10601, 8'h00);
    host.wr(17'h10604, 8'h09);
    host.wr(17'h10609, 8'h0c);
    host.wr(17'h10601, 8'h00);
    #1 chk({12'h000, activeMain}, 16'h0001);
    host.wr(17'h10609, 8'h02);
    host.wr(17'h10619, 8'h0e);
    host.wr(17'h10601, 8'h00);
    @(posedge clk_sys);
    #1 chk({15'h0000, decryptToNvm}, 16'h0001);
    host.wr(17'h10619, 8'h0a);
    host.wr(17'h10601, 8'h00);
    #1 chk({15'h0000, launch}, 16'h0000);
    // Root serial creation: a reserved step code is refused, a defined one commits.
    host.wr(17'h10619, 8'h01);
    host.wr(17'h10609, 8'h07);
    host.wr(17'h1061d, 8'h05);
    host.wr(17'h10601, 8'h00);
    #1 chk({15'h0000, launch}, 16'h0000);
    host.wr(17'h1061d, 8'h02);
    host.wr(17'h10601, 8'h00);
    #1 chk({13'h0000, activeRoot}, 16'h0002);
    chk({12'h000, activeSub}, 16'h0007);
    host.wr(17'h10609, 8'h01);
    host.wr(17'h10619, 8'h01);
    host.wr(17'h10604, 8'h0f);
    host.wr(17'h1060f, 8'h02);
    host.wr(17'h10601, 8'h00);
    host.wr(17'h10602, 8'h00);
    #1 chk({15'h0000, overwriteLaunch}, 16'h0001);
    chk({12'h000, activeSub}, 16'h0002);
    host.wr(17'h1060f, 8'h01);
    host.wr(17'h10604, 8'h0b);
    host.wr(17'h10601, 8'h00);
    host.wr(17'h1060b, 8'h01);
    @(posedge clk_sys);
    #1 chk({15'h0000, counterBackupStart}, 16'h0001);
    host.wr(17'h1060b, 8'h00);
    @(posedge clk_sys);
    #1 chk({15'h0000, counterBackupStart}, 16'h0000);
    host.wr(17'h10604, 8'h01);
    host.wr(17'h10601, 8'h00);
    // Zone selections: the top corner first, then random picks.
    for (i = 0; i < 5; i = i + 1) begin
      seed = lfsr(seed);
      v = (i == 0) ? 8'hff : seed[7:0];
      if (v[3:0] == 4'h0)
        v[3:0] = 4'h1;
      host.wr(17'h1061a, v);
      @(posedge clk_sys);
      #1 chk(nvmPageAddr, 16'hf000 + {4'h0, v[3:0], 8'h00} + {8'h00, v[5:4], 6'h00});
      chk({14'h0000, zoneSliceNumber}, {14'h0000, v[7:6]});
      host.rd(17'h1061a, d);
      chk({8'h00, d}, {8'h00, v});
    end
    @(posedge clk_sys);
    cipherBufWrite <= 1'b1;
    cipherBufIndex <= 6'h05;
    cipherBufData <= 8'h3c;
    @(posedge clk_sys);
    cipherBufWrite <= 1'b0;
    host.rd(17'h10105, d);
    chk({8'h00, d}, 16'h003c);
    host.wr(17'h1061c, 8'h00);
    repeat (70) @(posedge clk_sys);
    for (i = 0; i < 64; i = i + 21) begin
      host.rd(17'h10100 + i[16:0], d);
      chk({8'h00, d}, {8'h00, i[7:0] ^ 8'h5a});
    end
    host.wr(17'h1061a, 8'h30);
    host.wr(17'h1061c, 8'h00);
    #1 chk({15'h0000, pageLoad}, 16'h0000);
    results;
  end
endmodule // cipher_ctrl_state_registers_tb_top
